// file: include/reg_store_if.sv
`timescale 1ns/10ps
// ==========================================================
// Port logic to register store
// ==========================================================
interface reg_store_if;
  logic                              wr_en;    // Byte write strobe
  logic [serial_port_pkg::ADDR_W-1:0] wr_addr; // Write address
  logic [7:0]                        wr_data;  // Write byte
  logic                              rd_en;    // Fetch request
  logic [serial_port_pkg::ADDR_W-1:0] rd_addr; // Fetch address
  logic [7:0]                        rd_data;  // Registered read byte
  modport port  (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
  modport store (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface : reg_store_if

// file: include/serial_port_pkg.sv
package serial_port_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CORE_CLK_PERIOD_NS = 4;    // Core clock period
  localparam int SCLK_MAX_MHZ       = 20;   // Fastest serial clock
  localparam int SCLK_MIN_HALF_NS   = 1000 / (2 * SCLK_MAX_MHZ);
  // Least half period, rounded up to whole core cycles
  localparam int SCLK_MIN_HALF_CYC  =
    (SCLK_MIN_HALF_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int READ_PIPE_CYC      = 4;    // Sync, request, fetch, load

  // ==========================================================
  // Address space
  // ==========================================================
  localparam int              ADDR_W   = 5;
  localparam logic [ADDR_W-1:0] ADDR_TOP = 5'h1F;  // Highest mapped
  localparam logic [ADDR_W-1:0] ADDR_BOT = 5'h00;  // Lowest mapped
  localparam logic [ADDR_W-1:0] CFG_ADDR = 5'h00;  // Port config register

  // ==========================================================
  // Instruction byte fields
  // ==========================================================
  localparam int INS_DIR_BIT = 7;   // One reads, zero writes
  localparam int INS_CNT_HI  = 6;   // byte_count_hi
  localparam int INS_CNT_LO  = 5;   // byte_count_lo
  localparam int INS_ADDR_HI = 4;   // Top of short address

  // ==========================================================
  // Port configuration register
  // ==========================================================
  localparam int         CFG_W        = 8;
  localparam int         CFG_BIDIR    = 7;  // Shared data pin reads back
  localparam int         CFG_LSB      = 6;  // low_bit_first_sel
  localparam int         CFG_SRST     = 5;  // Software reset; stored in cfg, never acted on
  localparam int         CFG_LONG     = 4;  // two_byte_instruction_en
  localparam logic [7:0] CFG_RESET    = 8'h00;

  // ==========================================================
  // Port sequencer states
  // ==========================================================
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_INSTR = 3'b010,
    ST_DATA  = 3'b100
  } port_state_t;
endpackage : serial_port_pkg

// file: logic/reg_store.sv
`timescale 1ns/10ps
// ==========================================================
// Register byte store, read data from a register
// ==========================================================
module reg_store #(
  parameter int DEPTH = 32                  // Bytes held
) (
  input  wire logic core_clk_i,
  input  wire logic clk_en_i,
  input  wire logic reset_i,
  reg_store_if.store bus
);
  import serial_port_pkg::*;

  // Only a full five-bit space can be served
  if (DEPTH != 32) begin : g_bad_depth
    $error("reg_store: DEPTH must be 32");
  end

  logic [7:0] mem [DEPTH];      // Contents survive both resets
  logic [7:0] rd_data;          // Read register
  logic [7:0] next_rd_data;

  // Read mux, holds when idle
  always_comb begin
    next_rd_data = rd_data;
    if (bus.rd_en) begin
      next_rd_data = mem[bus.rd_addr];
    end
  end

  // Contents: no reset, data is not touched by resets
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i && bus.wr_en) begin
      mem[bus.wr_addr] <= bus.wr_data;
    end
  end

  // Read register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rd_data <= 8'h00;
    end else if (clk_en_i) begin
      rd_data <= next_rd_data;
    end
  end

  assign bus.rd_data = rd_data;
endmodule : reg_store

// file: logic/serial_register_port.sv
`timescale 1ns/10ps
// Contract
// - First eight rising edges carry the instruction
// - Decode direction, count, address; run data phase
// - Data phase is one to four bytes
// - Write lands as each byte completes
// - Chip select high on byte boundary stalls
// - Chip select high mid-byte abandons to idle
// - Instruction bit seven: one reads, zero writes
// - Bits six and five give byte count
// - Short address; multibyte addresses generated internally
// - Long mode: second instruction byte holds low address
// - Addresses above top are unmapped
// - Multibyte transfers, either bit order selectable
// - Readback on shared pin or separate pin
// - Pin-mode strap disables port, pins become controls
// - Sample on rising edge, clock at most 20 MHz
// - Chip select high floats both data pins
// - Address counts down MSB-first, up LSB-first
module serial_register_port (
  input  wire logic                             core_clk_i,
  input  wire logic                             reset_i,
  input  wire logic                             clk_en_i,
  input  wire logic                             pin_mode_i,
  input  wire logic                             chip_select_n_i,
  input  wire logic                             serial_clk_i,
  input  wire logic                             serial_data_io_i,
  output logic                                  serial_data_io_o,
  output logic                                  serial_data_io_oe_o,
  output logic                                  serial_data_out_o,
  output logic                                  serial_data_out_oe_o,
  output logic [serial_port_pkg::CFG_W-1:0]     port_config_o,
  output logic [2:0]                            pin_ctrl_o
);
  import serial_port_pkg::*;

  // Reads need the pipeline to finish inside one half serial period
  if (READ_PIPE_CYC > SCLK_MIN_HALF_CYC) begin : g_bad_rate
    $error("serial_register_port: core clock too slow for serial clock");
  end

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [3:0] meta, next_meta;  // First stage, read only by sync
  logic [3:0] sync, next_sync;  // {pin, csn, sclk, data}
  logic       sclk_d, next_sclk_d;  // Delayed sclk for edges
  logic       pin_s, csn_s, sclk_s, din_s;
  logic       rise, fall;

  assign {pin_s, csn_s, sclk_s, din_s} = sync;
  assign rise = sclk_s & ~sclk_d;
  assign fall = ~sclk_s & sclk_d;

  always_comb begin
    next_meta   = {pin_mode_i, chip_select_n_i, serial_clk_i, serial_data_io_i};
    next_sync   = meta;
    next_sclk_d = sclk_s;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      meta   <= 4'h4;
      sync   <= 4'h4;
      sclk_d <= 1'b0;
    end else if (clk_en_i) begin
      meta   <= next_meta;
      sync   <= next_sync;
      sclk_d <= next_sclk_d;
    end
  end

  // ==========================================================
  // Sequencer state
  // ==========================================================
  reg_store_if mem_bus ();

  port_state_t       state, next_state;
  logic [2:0]        bit_cnt, next_bit_cnt;      // Bits in this byte
  logic [7:0]        shreg, next_shreg;          // Incoming byte
  logic              is_read, next_is_read;
  logic [1:0]        left, next_left;            // Bytes left minus one
  logic [ADDR_W-1:0] addr, next_addr;            // Current register
  logic              oob, next_oob;              // Address above top
  logic              ins2, next_ins2;            // Awaiting second byte
  logic [CFG_W-1:0]  cfg, next_cfg;              // Port configuration
  logic [7:0]        tx, next_tx;                // Outgoing byte
  logic              tx_on, next_tx_on;          // Output started
  logic              out_bit, next_out_bit;
  logic              io_oe, next_io_oe;
  logic              so_oe, next_so_oe;
  logic              rd_wait, next_rd_wait;      // Fetch in flight
  logic [1:0]        rd_sel, next_rd_sel;        // {oob, config}
  logic [2:0]        pins, next_pins;            // Pin-mode controls
  logic [7:0]        shifted;
  logic              lsb, byte_done, rd_req, drive;

  // Next address, saturating at the ends of the map
  function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a,
                                             input logic up);
    if (up) begin
      step = (a == ADDR_TOP) ? a : ADDR_W'(a + 1'b1);
    end else begin
      step = (a == ADDR_BOT) ? a : ADDR_W'(a - 1'b1);
    end
  endfunction : step

  assign lsb       = cfg[CFG_LSB];
  assign shifted   = lsb ? {din_s, shreg[7:1]} : {shreg[6:0], din_s};
  assign byte_done = rise && !csn_s && !pin_s && (bit_cnt == 3'd7);

  // Sequencer next state
  always_comb begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_shreg   = shreg;
    next_is_read = is_read;
    next_left    = left;
    next_addr    = addr;
    next_oob     = oob;
    next_ins2    = ins2;
    next_cfg     = cfg;
    next_tx      = tx;
    next_tx_on   = tx_on;
    next_out_bit = out_bit;
    next_rd_wait = 1'b0;
    next_rd_sel  = rd_sel;
    next_pins    = pin_s ? {csn_s, sclk_s, din_s} : 3'b000;
    rd_req       = 1'b0;
    mem_bus.wr_en = 1'b0;
    if (rd_wait) begin
      // Load the fetched byte before the next falling edge
      next_tx = rd_sel[1] ? 8'h00 : (rd_sel[0] ? cfg : mem_bus.rd_data);
    end
    if (pin_s) begin
      // Strap high: port held idle
      next_state   = ST_IDLE;
      next_bit_cnt = 3'd0;
    end else if (csn_s) begin
      if (bit_cnt != 3'd0) begin
        // Broken byte: drop the cycle
        next_state   = ST_IDLE;
        next_bit_cnt = 3'd0;
      end
      // Otherwise a byte-boundary stall: everything holds
    end else begin
      case (state)
        ST_IDLE: begin
          next_state   = ST_INSTR;
          next_bit_cnt = 3'd0;
          next_ins2    = 1'b0;
          next_tx_on   = 1'b0;
        end
        ST_INSTR: begin
          if (rise) begin
            next_shreg   = shifted;
            next_bit_cnt = 3'(bit_cnt + 1'b1);
            if (bit_cnt == 3'd7) begin
              if (!ins2) begin
                next_is_read = shifted[INS_DIR_BIT];
                next_left    = shifted[INS_CNT_HI:INS_CNT_LO];
                next_addr    = shifted[INS_ADDR_HI:0];
                next_oob     = 1'b0;
                if (cfg[CFG_LONG]) begin
                  // First byte carries address bits 12 to 8
                  next_ins2 = 1'b1;
                  next_oob  = |shifted[INS_ADDR_HI:0];
                end else begin
                  next_state = ST_DATA;
                  rd_req     = shifted[INS_DIR_BIT];
                end
              end else begin
                next_addr  = shifted[ADDR_W-1:0];
                next_oob   = oob | (|shifted[7:ADDR_W]);
                next_state = ST_DATA;
                rd_req     = is_read;
              end
            end
          end
        end
        ST_DATA: begin
          if (rise) begin
            next_shreg   = shifted;
            next_bit_cnt = 3'(bit_cnt + 1'b1);
            if (bit_cnt == 3'd7) begin
              if (!is_read) begin
                mem_bus.wr_en = !oob;
                if (!oob && addr == CFG_ADDR) begin
                  next_cfg = shifted;
                end
              end
              next_addr = step(addr, lsb);
              if (left == 2'd0) begin
                next_state = ST_IDLE;
              end else begin
                next_left = 2'(left - 1'b1);
                rd_req    = is_read;
              end
            end
          end
          if (fall && is_read) begin
            // Drive one bit per falling edge; host samples on rising
            next_out_bit = lsb ? tx[0] : tx[7];
            next_tx      = lsb ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0};
            next_tx_on   = 1'b1;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
    if (rd_req) begin
      next_rd_wait = 1'b1;
      next_rd_sel  = {next_oob, next_addr == CFG_ADDR};
    end
    // Pins float unless a read is under way with chip select low
    drive      = next_tx_on && next_is_read && (next_state == ST_DATA) && !csn_s && !pin_s;
    next_io_oe = drive && cfg[CFG_BIDIR];
    next_so_oe = drive && !cfg[CFG_BIDIR];
  end

  assign mem_bus.wr_addr = addr;
  assign mem_bus.wr_data = shifted;
  assign mem_bus.rd_en   = rd_req;
  assign mem_bus.rd_addr = next_addr;

  // Sequencer registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state   <= ST_IDLE;
      bit_cnt <= 3'd0;
      shreg   <= 8'h00;
      is_read <= 1'b0;
      left    <= 2'd0;
      addr    <= ADDR_BOT;
      oob     <= 1'b0;
      ins2    <= 1'b0;
      cfg     <= CFG_RESET;
      tx      <= 8'h00;
      tx_on   <= 1'b0;
      out_bit <= 1'b0;
      io_oe   <= 1'b0;
      so_oe   <= 1'b0;
      rd_wait <= 1'b0;
      rd_sel  <= 2'b00;
      pins    <= 3'b000;
    end else if (clk_en_i) begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
      is_read <= next_is_read;
      left    <= next_left;
      addr    <= next_addr;
      oob     <= next_oob;
      ins2    <= next_ins2;
      cfg     <= next_cfg;
      tx      <= next_tx;
      tx_on   <= next_tx_on;
      out_bit <= next_out_bit;
      io_oe   <= next_io_oe;
      so_oe   <= next_so_oe;
      rd_wait <= next_rd_wait;
      rd_sel  <= next_rd_sel;
      pins    <= next_pins;
    end
  end

  reg_store #(.DEPTH(32)) u_store (
    .core_clk_i (core_clk_i),
    .clk_en_i   (clk_en_i),
    .reset_i    (reset_i),
    .bus        (mem_bus.store)
  );

  assign serial_data_io_o     = out_bit;
  assign serial_data_out_o    = out_bit;
  assign serial_data_io_oe_o  = io_oe;
  assign serial_data_out_oe_o = so_oe;
  assign port_config_o        = cfg;
  assign pin_ctrl_o           = pins;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge core_clk_i iff clk_en_i); endclocking
  default disable iff (reset_i);

  sequence s_read_step;
    byte_done && is_read && state == ST_DATA && left != 2'd0;
  endsequence
  sequence s_loaded;
    rd_wait ##1 !rd_wait;
  endsequence

  property p_instr_end;
    state == ST_INSTR && byte_done && !ins2 && !cfg[CFG_LONG] |=> state == ST_DATA;
  endproperty
  a_instr_end: assert property (p_instr_end) else $error("instruction not ended");
  property p_write_now;
    state == ST_DATA && byte_done && !is_read && !oob |-> mem_bus.wr_en;
  endproperty
  a_write_now: assert property (p_write_now) else $error("write not immediate");
  property p_abandon;
    state != ST_IDLE && csn_s && !pin_s && bit_cnt != 3'd0 |=> state == ST_IDLE;
  endproperty
  a_abandon: assert property (p_abandon) else $error("broken byte kept");
  property p_stall;
    state == ST_DATA && csn_s && bit_cnt == 3'd0 |=> $stable(addr) && $stable(left);
  endproperty
  a_stall: assert property (p_stall) else $error("stall lost state");
  property p_float;
    csn_s ##1 csn_s |-> !io_oe && !so_oe;
  endproperty
  a_float: assert property (p_float) else $error("pin driven while deselected");
  property p_pin_mode;
    pin_s |=> state == ST_IDLE && !io_oe && !so_oe;
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("port active in pin mode");
  property p_count_down;
    state == ST_DATA && byte_done && !lsb && addr != ADDR_BOT
      |=> addr == ADDR_W'($past(addr) - 1'b1);
  endproperty
  a_count_down: assert property (p_count_down) else $error("address not decremented");
  property p_one_pin;
    !(io_oe && so_oe);
  endproperty
  a_one_pin: assert property (p_one_pin) else $error("both data pins driven");
  property p_read_fetch;
    s_read_step |=> s_loaded;
  endproperty
  a_read_fetch: assert property (p_read_fetch) else $error("read byte not fetched");
endmodule : serial_register_port

// file: verification/host_master_model.sv
`timescale 1ns/10ps
// ==========================================
// Host serial master; sclk idles low between frames
// ==========================================
module host_master_model (
  input  wire logic       core_clk_i,
  input  wire logic       dev_io_i,        // Device drive on shared pin
  input  wire logic       dev_io_oe_i,     // Device owns shared pin
  input  wire logic       dev_out_i,       // Device separate out pin
  input  wire logic       dev_out_oe_i,    // Device owns out pin
  output logic            chip_select_n_o,
  output logic            serial_clk_o,
  output logic            serial_data_o,   // Resolved shared pin level
  output logic [1:0]      oe_seen_o        // Enables at last read sample
);
  logic host_oe   = 1'h0;  // Host owns shared pin
  logic host_d    = 1'h0;  // Host bit
  logic float_pat = 1'h0;  // No pull: floating pins wander
  logic sdo_lvl;           // Resolved out pin level
  initial begin
    chip_select_n_o = 1'h1;
    serial_clk_o    = 1'h0;
    oe_seen_o       = 2'h0;
  end
  // Moving pattern so a released pin never looks like old data
  always @(posedge core_clk_i) float_pat <= ~float_pat;
  assign serial_data_o = dev_io_oe_i ? dev_io_i : (host_oe ? host_d : float_pat);
  assign sdo_lvl       = dev_out_oe_i ? dev_out_i : float_pat;
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : wait_cyc
  // Lead of 3 cycles so select is seen before the first rise
  task automatic open_frame();
    chip_select_n_o = 1'h0;
    wait_cyc(3);
  endtask : open_frame
  task automatic close_frame();
    wait_cyc(2);
    host_oe         = 1'h0;
    chip_select_n_o = 1'h1;
    wait_cyc(6);
  endtask : close_frame
  // Stall only ever on a byte boundary
  task automatic pause();
    wait_cyc(3);
    chip_select_n_o = 1'h1;
    wait_cyc(10);
    chip_select_n_o = 1'h0;
    wait_cyc(3);
  endtask : pause
  // Half period 6 cycles (24 ns); read sampled just before the rise
  task automatic shift(input logic [7:0] tx, input int nbits, input logic drive,
                       input logic lsb, input logic shared, output logic [7:0] rx);
    int idx;
    rx = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      idx     = lsb ? i : 7 - i;
      host_oe = drive;
      host_d  = tx[idx];
      wait_cyc(5);
      rx[idx] = shared ? serial_data_o : sdo_lvl;
      if (!drive) oe_seen_o = {dev_io_oe_i, dev_out_oe_i};
      wait_cyc(1);
      serial_clk_o = 1'h1;
      wait_cyc(6);
      serial_clk_o = 1'h0;
    end
  endtask : shift
  // Static levels for strap mode
  task automatic set_pins(input logic c, input logic s, input logic d);
    chip_select_n_o = c;
    serial_clk_o    = s;
    host_oe         = 1'h1;
    host_d          = d;
  endtask : set_pins
endmodule : host_master_model

// file: verification/tb_top.sv
`timescale 1ns/10ps
// ==========================================
// Serial register port bench
// ==========================================
module tb_top;
  import serial_port_pkg::*;
  logic             core_clk = 1'h0;
  logic             reset    = 1'h1;
  logic             pin_mode = 1'h0;
  logic             clk_en   = 1'h1;
  wire logic        csn, sclk, sdio;
  logic             io_o, io_oe, out_o, out_oe;
  logic [CFG_W-1:0] cfg;
  logic [2:0]       pin_ctrl;
  logic [1:0]       oe_seen;
  int               fails  = 0;
  int               checks = 0;
  logic [7:0]       mem [32];          // Expected register contents
  logic             lsb_mode    = 1'h0; // Host copy of port config
  logic             shared_mode = 1'h0;
  logic             long_mode   = 1'h0;
  always #2 core_clk = ~core_clk;
  serial_register_port uut (
    .core_clk_i(core_clk), .reset_i(reset), .clk_en_i(clk_en), .pin_mode_i(pin_mode),
    .chip_select_n_i(csn), .serial_clk_i(sclk), .serial_data_io_i(sdio),
    .serial_data_io_o(io_o), .serial_data_io_oe_o(io_oe), .serial_data_out_o(out_o),
    .serial_data_out_oe_o(out_oe), .port_config_o(cfg), .pin_ctrl_o(pin_ctrl));
  host_master_model host (
    .core_clk_i(core_clk), .dev_io_i(io_o), .dev_io_oe_i(io_oe), .dev_out_i(out_o),
    .dev_out_oe_i(out_oe), .chip_select_n_o(csn), .serial_clk_o(sclk),
    .serial_data_o(sdio), .oe_seen_o(oe_seen));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One full cycle; expectations come from the shadow copy
  task automatic access(input logic rd, input int n, input logic [12:0] a,
                        input logic [31:0] wd, input logic stall);
    logic [7:0]  rx;
    logic [12:0] cur;
    cur = a;
    host.open_frame();
    if (long_mode) begin
      host.shift({rd, 2'(n - 1), a[12:8]}, 8, 1'h1, lsb_mode, shared_mode, rx);
      host.shift(a[7:0], 8, 1'h1, lsb_mode, shared_mode, rx);
    end else begin
      host.shift({rd, 2'(n - 1), a[4:0]}, 8, 1'h1, lsb_mode, shared_mode, rx);
    end
    for (int k = 0; k < n; k++) begin
      host.shift(wd[8*k +: 8], 8, !rd, lsb_mode, shared_mode, rx);
      if (rd) check("read byte", rx, (cur > 13'h001F) ? 8'h00 : mem[cur[4:0]]);
      else if (cur <= 13'h001F) mem[cur[4:0]] = wd[8*k +: 8];
      if (!lsb_mode) cur = (cur == 13'h0000) ? cur : cur - 13'h0001;
      else cur = (cur == 13'h001F) ? cur : cur + 13'h0001;
      if (stall && k == 0) host.pause();
    end
    // Config lands while select is still low
    if (!rd && a == 13'h0000) check("config", cfg, wd[7:0]);
    if (rd) check("read enables", {6'h00, oe_seen}, shared_mode ? 8'h02 : 8'h01);
    host.close_frame();
    check("idle enables", {6'h00, io_oe, out_oe}, 8'h00);
    if (!rd && a == 13'h0000) begin
      shared_mode = wd[CFG_BIDIR];
      lsb_mode    = wd[CFG_LSB];
      long_mode   = wd[CFG_LONG];
    end
  endtask : access
  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask : done
  task automatic t_reset();
    check("config at reset", cfg, CFG_RESET);
    check("pin controls", {5'h00, pin_ctrl}, 8'h00);
    check("enables at reset", {6'h00, io_oe, out_oe}, 8'h00);
    done("reset");
  endtask : t_reset
  // Single byte, MSB first, separate out pin
  task automatic t_single();
    access(1'h0, 1, 13'h0003, 32'h0000003C, 1'h0);
    access(1'h1, 1, 13'h0003, 32'h00000000, 1'h0);
    done("single");
  endtask : t_single
  // Four bytes with a stall after the first
  task automatic t_multi();
    access(1'h0, 4, 13'h0007, 32'hA1B2C3D4, 1'h1);
    access(1'h1, 4, 13'h0007, 32'h00000000, 1'h1);
    done("multi");
  endtask : t_multi
  // Select raised mid byte in data, then mid instruction
  task automatic t_abandon();
    logic [7:0] rx;
    host.open_frame();
    host.shift(8'h03, 8, 1'h1, 1'h0, 1'h0, rx);
    host.shift(8'hFF, 5, 1'h1, 1'h0, 1'h0, rx);
    host.close_frame();
    host.open_frame();
    host.shift(8'h83, 4, 1'h1, 1'h0, 1'h0, rx);
    host.close_frame();
    access(1'h1, 1, 13'h0003, 32'h00000000, 1'h0);
    done("abandon");
  endtask : t_abandon
  // LSB first on shared pin; address saturates at top
  task automatic t_lsb();
    access(1'h0, 1, 13'h0000, 32'h000000E0, 1'h0);
    access(1'h0, 3, 13'h001E, 32'h00665544, 1'h0);
    access(1'h1, 2, 13'h001E, 32'h00000000, 1'h1);
    access(1'h1, 1, 13'h0000, 32'h00000000, 1'h0);
    done("lsb");
  endtask : t_lsb
  // Two byte instruction; unmapped space is dropped
  task automatic t_long();
    access(1'h0, 1, 13'h0000, 32'h00000010, 1'h0);
    access(1'h1, 1, 13'h0123, 32'h00000000, 1'h0);
    access(1'h0, 1, 13'h0105, 32'h000000EE, 1'h0);
    access(1'h1, 1, 13'h0005, 32'h00000000, 1'h0);
    access(1'h0, 1, 13'h0000, 32'h00000000, 1'h0);
    done("long");
  endtask : t_long
  // Strap mode: pins become plain controls, port silent
  task automatic t_pinmode();
    pin_mode = 1'h1;
    host.set_pins(1'h1, 1'h0, 1'h1);
    host.wait_cyc(6);
    check("pin controls", {5'h00, pin_ctrl}, 8'h05);
    host.set_pins(1'h0, 1'h1, 1'h0);
    host.wait_cyc(6);
    check("pin controls", {5'h00, pin_ctrl}, 8'h02);
    host.set_pins(1'h1, 1'h0, 1'h0);
    host.wait_cyc(6);
    check("strap enables", {6'h00, io_oe, out_oe}, 8'h00);
    pin_mode = 1'h0;
    host.wait_cyc(6);
    check("pin controls", {5'h00, pin_ctrl}, 8'h00);
    access(1'h1, 1, 13'h0003, 32'h00000000, 1'h0);
    done("pinmode");
  endtask : t_pinmode
  // Enable low freezes the port; mid-run reset clears config, keeps contents
  task automatic t_freeze();
    access(1'h0, 1, 13'h0000, 32'h000000C0, 1'h0);
    clk_en   = 1'h0;
    pin_mode = 1'h1;
    host.set_pins(1'h1, 1'h1, 1'h1);
    host.wait_cyc(6);
    check("frozen controls", {5'h00, pin_ctrl}, 8'h00);
    clk_en = 1'h1;
    host.wait_cyc(6);
    check("pin controls", {5'h00, pin_ctrl}, 8'h07);
    pin_mode = 1'h0;
    host.set_pins(1'h1, 1'h0, 1'h0);
    reset = 1'h1;
    host.wait_cyc(2);
    reset = 1'h0;
    host.wait_cyc(2);
    check("config after reset", cfg, CFG_RESET);
    check("enables after reset", {6'h00, io_oe, out_oe}, 8'h00);
    shared_mode = 1'h0;
    lsb_mode    = 1'h0;
    long_mode   = 1'h0;
    mem[0]      = CFG_RESET;
    access(1'h1, 1, 13'h0003, 32'h00000000, 1'h0);
    done("freeze");
  endtask : t_freeze
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(negedge core_clk);
    reset = 1'h0;
    repeat (2) @(negedge core_clk);
    t_reset();
    t_single();
    t_multi();
    t_abandon();
    t_lsb();
    t_long();
    t_pinmode();
    t_freeze();
    end_of_test();
  end
endmodule : tb_top
